/* File: design/pfs_cfg.svh */
`ifndef PFS_CFG_SVH
`define PFS_CFG_SVH

// ==========================================================================
// Register map.
`define PFS_ADDR_W 4
`define PFS_OFS_ANALOG_SEL 4'h0
`define PFS_OFS_SERIAL_SEL 4'h2
`define PFS_OFS_STATUS 4'h4

// ==========================================================================
// Reset values and writable masks.
`define PFS_ANALOG_RESET 16'h0000
`define PFS_ANALOG_WMASK 16'h00FF
`define PFS_SERIAL_RESET 16'h0A88
`define PFS_SERIAL_WMASK 16'h0FFF

// ==========================================================================
// Field positions in the serial selection register.
`define PFS_SER_CH0_LSB 0
`define PFS_SER_P1_LSB 2
`define PFS_SER_CH2_LSB 4
`define PFS_SER_P3_LSB 6
`define PFS_SER_P4_LSB 8
`define PFS_SER_P5_LSB 10

// ==========================================================================
// Status register bit positions.
`define PFS_ST_CH0_TX_OWNED 0
`define PFS_ST_CH0_RX_OWNED 1
`define PFS_ST_CH2_TX_OWNED 2
`define PFS_ST_CH2_RX_OWNED 3
`define PFS_ST_ANALOG_CONFLICT 4
`define PFS_ST_RESERVED_CODE 5

`endif

/* File: design/pfs_pkg.sv */
package pfs_pkg;

    // ======================================================================
    // Decoded pin mode, one-hot.
    typedef enum logic [4:0] {
        PFS_PERIPH = 5'b00001,
        PFS_OUTPUT = 5'b00010,
        PFS_IN_PULL = 5'b00100,
        PFS_IN_NOPULL = 5'b01000,
        PFS_RESERVED = 5'b10000
    } pfs_mode_e;

    // Code 01 is general output only where the pin supports it.
    function automatic pfs_mode_e pfs_decode(input logic [1:0] field, input logic out_ok);
        pfs_mode_e m;
        m = PFS_PERIPH;
        unique case (field)
            2'h0: m = PFS_PERIPH;
            2'h1: m = out_ok ? PFS_OUTPUT : PFS_RESERVED;
            2'h2: m = PFS_IN_PULL;
            2'h3: m = PFS_IN_NOPULL;
        endcase
        return m;
    endfunction

endpackage

/* File: design/pfs_serial_chan.sv */
`timescale 1ns/1ns

module pfs_serial_chan
    import pfs_pkg::*;
(
    input wire logic [1:0] mode_field,
    input wire logic transmit_enable,
    input wire logic receive_enable,
    input wire logic ser_txd,
    input wire logic shared_data_bit,
    input wire logic receive_pin_in,
    output logic transmit_pin_out,
    output logic transmit_pin_oe,
    output logic receive_pin_pullup,
    output logic ser_rxd,
    output logic shared_data_read,
    output logic tx_owned,
    output logic rx_owned
);

    pfs_mode_e mode;

    assign mode = pfs_decode(mode_field, 1'b1); // see RULE_10

    // ======================================================================
    // Transmit pin.
    always_comb begin
        tx_owned = transmit_enable; // see RULE_05
        transmit_pin_out = 1'b1;
        transmit_pin_oe = 1'b0;
        if (transmit_enable) begin
            transmit_pin_out = ser_txd; // see RULE_06
            transmit_pin_oe = 1'b1; // see RULE_13
        end else if (mode == PFS_OUTPUT) begin
            transmit_pin_out = shared_data_bit; // see RULE_12
            transmit_pin_oe = 1'b1;
        end
    end

    // ======================================================================
    // Receive pin. The receiver sees idle level when the port owns the pin.
    always_comb begin
        rx_owned = receive_enable; // see RULE_05
        receive_pin_pullup = 1'b0;
        ser_rxd = receive_pin_in;
        shared_data_read = shared_data_bit;
        if (!receive_enable && mode_field[1]) begin
            receive_pin_pullup = (mode == PFS_IN_PULL);
            ser_rxd = 1'b1;
            shared_data_read = receive_pin_in; // see RULE_12
        end
    end

endmodule

/* File: design/pfs_top.sv */
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ns

`include "pfs_cfg.svh"

// Notes on behaviour
// RULE_01: Analog selection register bits 15:8 read zero; writes there are dropped.
// RULE_02: Analog pin fields: 00 peripheral, 01 reserved, 10 and 11 port input.
// RULE_03: Software confirms analog output is off before choosing port input.
// RULE_04: Serial selection register bits 15:12 read zero; writes there are dropped.
// RULE_05: Serial pin settings act only while that channel's transmit and receive are off; the code gates each pin only by its own enable.
// RULE_06: Transmit enable set gives the transmit pin to the transmitter.
// RULE_07: Receive enable set makes the receive pin a receiver input.
// RULE_08: Bits 11:10: 00 peripheral, 01 reserved, 10 pulled input, 11 input; reset 10.
// RULE_09: Bits 9:8, 7:6, 3:2: peripheral, output, pulled input, input; reset upper bit set.
// RULE_10: Channel two field picks serial, general output, pulled or plain general input.
// RULE_11: Channel zero field works like channel two and resets to serial use.
// RULE_12: One shared data bit per channel: output via transmit pin, input via receive pin.
// RULE_13: In port input mode transmit pin drives if transmit enabled, else floats.
// RULE_14: Reserved bit writes are ignored so those bits always read zero.
module pfs_top
    import pfs_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [`PFS_ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic analog_output_enable,
    input wire logic [3:0] analog_pin_in,
    output logic [3:0] analog_port_in_en,
    output logic [3:0] analog_port_read,
    input wire logic [1:0] transmit_enable,
    input wire logic [1:0] receive_enable,
    input wire logic [1:0] ser_txd,
    output logic [1:0] ser_rxd,
    input wire logic chan0_shared_data_bit,
    output logic chan0_shared_data_read,
    output logic chan0_transmit_pin_out,
    output logic chan0_transmit_pin_oe,
    input wire logic chan0_receive_pin_in,
    output logic chan0_receive_pin_pullup,
    input wire logic chan2_shared_data_bit,
    output logic chan2_shared_data_read,
    output logic chan2_transmit_pin_out,
    output logic chan2_transmit_pin_oe,
    input wire logic chan2_receive_pin_in,
    output logic chan2_receive_pin_pullup,
    input wire logic [3:0] gen_pin_in,
    input wire logic [3:0] gen_periph_out,
    input wire logic [3:0] gen_periph_oe,
    input wire logic [3:0] gen_port_data,
    output logic [3:0] gen_pin_out,
    output logic [3:0] gen_pin_oe,
    output logic [3:0] gen_pin_pullup,
    output logic [3:0] gen_port_read
);

    // ======================================================================
    // Selection registers.
    logic [15:0] analog_sel_r;
    logic [15:0] serial_sel_r;
    logic [15:0] reg_rdata_r;
    logic [15:0] reg_rdata_nxt;
    logic [15:0] status_nxt;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            analog_sel_r <= `PFS_ANALOG_RESET;
        end else if (reg_wr && reg_addr == `PFS_OFS_ANALOG_SEL) begin
            analog_sel_r <= reg_wdata & `PFS_ANALOG_WMASK; // see RULE_01
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            serial_sel_r <= `PFS_SERIAL_RESET; // see RULE_08
        end else if (reg_wr && reg_addr == `PFS_OFS_SERIAL_SEL) begin
            serial_sel_r <= reg_wdata & `PFS_SERIAL_WMASK; // see RULE_04
        end
    end

    // ======================================================================
    // Read port. Data stand only in the cycle after the strobe; unmapped reads give zero.
    always_comb begin
        reg_rdata_nxt = 16'h0000;
        if (reg_rd) begin
            unique case (reg_addr)
                `PFS_OFS_ANALOG_SEL: reg_rdata_nxt = analog_sel_r & `PFS_ANALOG_WMASK; // see RULE_14
                `PFS_OFS_SERIAL_SEL: reg_rdata_nxt = serial_sel_r & `PFS_SERIAL_WMASK; // see RULE_14
                `PFS_OFS_STATUS: reg_rdata_nxt = status_r;
                default: reg_rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata_r <= 16'h0000;
        end else begin
            reg_rdata_r <= reg_rdata_nxt;
        end
    end

    assign reg_rdata = reg_rdata_r;

    // ======================================================================
    // Analog-shared pins. Code 01 keeps the input buffer off, like the peripheral setting,
    // so a forbidden write cannot load the analog output.
    logic [3:0] analog_in_en_nxt;
    logic [3:0] analog_read_nxt;
    logic analog_reserved;
    logic [3:0] analog_in_en_r;
    logic [3:0] analog_read_r;

    always_comb begin
        analog_reserved = 1'b0;
        for (int i = 0; i < 4; i++) begin
            pfs_mode_e m;
            m = pfs_decode(analog_sel_r[2*i +: 2], 1'b0); // see RULE_02
            analog_in_en_nxt[i] = (m == PFS_IN_PULL) || (m == PFS_IN_NOPULL);
            analog_read_nxt[i] = analog_in_en_nxt[i] & analog_pin_in[i];
            if (m == PFS_RESERVED) begin
                analog_reserved = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            analog_in_en_r <= 4'h0;
            analog_read_r <= 4'h0;
        end else begin
            analog_in_en_r <= analog_in_en_nxt;
            analog_read_r <= analog_read_nxt;
        end
    end

    assign analog_port_in_en = analog_in_en_r;
    assign analog_port_read = analog_read_r;

    // ======================================================================
    // General serial-group pins, index 0..3 for pins 1, 3, 4 and 5.
    // Pin 5 has no output code; its reserved code floats the pin without pull-up.
    logic [1:0] gen_field [4];
    logic [3:0] gen_out_ok;
    logic [3:0] gen_out_nxt;
    logic [3:0] gen_oe_nxt;
    logic [3:0] gen_pull_nxt;
    logic [3:0] gen_read_nxt;
    logic gen_reserved;
    logic [3:0] gen_out_r;
    logic [3:0] gen_oe_r;
    logic [3:0] gen_pull_r;
    logic [3:0] gen_read_r;

    assign gen_field[0] = serial_sel_r[`PFS_SER_P1_LSB +: 2];
    assign gen_field[1] = serial_sel_r[`PFS_SER_P3_LSB +: 2];
    assign gen_field[2] = serial_sel_r[`PFS_SER_P4_LSB +: 2];
    assign gen_field[3] = serial_sel_r[`PFS_SER_P5_LSB +: 2];
    assign gen_out_ok = 4'h7; // see RULE_08

    always_comb begin
        gen_reserved = 1'b0;
        for (int i = 0; i < 4; i++) begin
            pfs_mode_e m;
            m = pfs_decode(gen_field[i], gen_out_ok[i]); // see RULE_09
            gen_out_nxt[i] = 1'b1;
            gen_oe_nxt[i] = 1'b0;
            gen_pull_nxt[i] = 1'b0;
            gen_read_nxt[i] = gen_port_data[i];
            unique case (m)
                PFS_PERIPH: begin
                    gen_out_nxt[i] = gen_periph_out[i];
                    gen_oe_nxt[i] = gen_periph_oe[i];
                end
                PFS_OUTPUT: begin
                    gen_out_nxt[i] = gen_port_data[i];
                    gen_oe_nxt[i] = 1'b1;
                end
                PFS_IN_PULL: begin
                    gen_pull_nxt[i] = 1'b1;
                    gen_read_nxt[i] = gen_pin_in[i];
                end
                PFS_IN_NOPULL: begin
                    gen_read_nxt[i] = gen_pin_in[i];
                end
                PFS_RESERVED: begin
                    gen_reserved = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gen_out_r <= 4'hF;
            gen_oe_r <= 4'h0;
            gen_pull_r <= 4'h0;
            gen_read_r <= 4'h0;
        end else begin
            gen_out_r <= gen_out_nxt;
            gen_oe_r <= gen_oe_nxt;
            gen_pull_r <= gen_pull_nxt;
            gen_read_r <= gen_read_nxt;
        end
    end

    assign gen_pin_out = gen_out_r;
    assign gen_pin_oe = gen_oe_r;
    assign gen_pin_pullup = gen_pull_r;
    assign gen_port_read = gen_read_r;

    // ======================================================================
    // Serial channels 0 and 2.
    logic [1:0] ch_tx_out;
    logic [1:0] ch_tx_oe;
    logic [1:0] ch_rx_pull;
    logic [1:0] ch_rxd;
    logic [1:0] ch_read;
    logic [1:0] ch_tx_owned;
    logic [1:0] ch_rx_owned;
    logic [1:0] ch_tx_out_r;
    logic [1:0] ch_tx_oe_r;
    logic [1:0] ch_rx_pull_r;
    logic [1:0] ch_rxd_r;
    logic [1:0] ch_read_r;
    logic [15:0] status_r;

    pfs_serial_chan u_chan0 (
        .mode_field(serial_sel_r[`PFS_SER_CH0_LSB +: 2]), // see RULE_11
        .transmit_enable(transmit_enable[0]),
        .receive_enable(receive_enable[0]),
        .ser_txd(ser_txd[0]),
        .shared_data_bit(chan0_shared_data_bit),
        .receive_pin_in(chan0_receive_pin_in),
        .transmit_pin_out(ch_tx_out[0]),
        .transmit_pin_oe(ch_tx_oe[0]),
        .receive_pin_pullup(ch_rx_pull[0]),
        .ser_rxd(ch_rxd[0]),
        .shared_data_read(ch_read[0]),
        .tx_owned(ch_tx_owned[0]),
        .rx_owned(ch_rx_owned[0])
    );

    pfs_serial_chan u_chan2 (
        .mode_field(serial_sel_r[`PFS_SER_CH2_LSB +: 2]), // see RULE_10
        .transmit_enable(transmit_enable[1]),
        .receive_enable(receive_enable[1]),
        .ser_txd(ser_txd[1]),
        .shared_data_bit(chan2_shared_data_bit),
        .receive_pin_in(chan2_receive_pin_in),
        .transmit_pin_out(ch_tx_out[1]),
        .transmit_pin_oe(ch_tx_oe[1]),
        .receive_pin_pullup(ch_rx_pull[1]),
        .ser_rxd(ch_rxd[1]),
        .shared_data_read(ch_read[1]),
        .tx_owned(ch_tx_owned[1]),
        .rx_owned(ch_rx_owned[1])
    );

    // Receive enable takes the pin as receiver input whatever the field says.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ch_tx_out_r <= 2'h3;
            ch_tx_oe_r <= 2'h0;
            ch_rx_pull_r <= 2'h0;
            ch_rxd_r <= 2'h3;
            ch_read_r <= 2'h0;
        end else begin
            ch_tx_out_r <= ch_tx_out;
            ch_tx_oe_r <= ch_tx_oe;
            ch_rx_pull_r <= ch_rx_pull & ~receive_enable; // see RULE_07
            ch_rxd_r <= ch_rxd;
            ch_read_r <= ch_read;
        end
    end

    assign chan0_transmit_pin_out = ch_tx_out_r[0];
    assign chan0_transmit_pin_oe = ch_tx_oe_r[0];
    assign chan0_receive_pin_pullup = ch_rx_pull_r[0];
    assign chan0_shared_data_read = ch_read_r[0];
    assign chan2_transmit_pin_out = ch_tx_out_r[1];
    assign chan2_transmit_pin_oe = ch_tx_oe_r[1];
    assign chan2_receive_pin_pullup = ch_rx_pull_r[1];
    assign chan2_shared_data_read = ch_read_r[1];
    assign ser_rxd = ch_rxd_r;

    // ======================================================================
    // Status: live view of pin ownership and of settings software should not make.
    // The analog conflict flag only reports; the block does not police software.
    always_comb begin
        status_nxt = 16'h0000;
        status_nxt[`PFS_ST_CH0_TX_OWNED] = ch_tx_owned[0];
        status_nxt[`PFS_ST_CH0_RX_OWNED] = ch_rx_owned[0];
        status_nxt[`PFS_ST_CH2_TX_OWNED] = ch_tx_owned[1];
        status_nxt[`PFS_ST_CH2_RX_OWNED] = ch_rx_owned[1];
        status_nxt[`PFS_ST_ANALOG_CONFLICT] = analog_output_enable & (|analog_in_en_nxt);
        status_nxt[`PFS_ST_RESERVED_CODE] = analog_reserved | gen_reserved;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_r <= 16'h0000;
        end else begin
            status_r <= status_nxt;
        end
    end

endmodule

/* File: testbench/pfs_top_assertions.sv */
`timescale 1ns/1ns

`include "pfs_cfg.svh"

// ==========================================================================
// Port-level checker for the pin select block.
module pfs_top_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic [`PFS_ADDR_W-1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [3:0] analog_pin_in,
    input wire logic [3:0] analog_port_in_en,
    input wire logic [3:0] analog_port_read,
    input wire logic [1:0] transmit_enable,
    input wire logic [1:0] receive_enable,
    input wire logic [1:0] ser_txd,
    input wire logic [1:0] ser_rxd,
    input wire logic chan0_transmit_pin_out,
    input wire logic chan0_transmit_pin_oe,
    input wire logic chan0_receive_pin_in,
    input wire logic chan0_receive_pin_pullup,
    input wire logic chan2_transmit_pin_out,
    input wire logic chan2_transmit_pin_oe,
    input wire logic chan2_shared_data_bit,
    input wire logic chan2_shared_data_read,
    input wire logic [3:0] gen_pin_oe,
    input wire logic [3:0] gen_pin_pullup
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    property p_ana_rsv; reg_rd && reg_addr == `PFS_OFS_ANALOG_SEL |=> reg_rdata[15:8] == 8'h00; endproperty
    a_ana_rsv: assert property (p_ana_rsv) else $error("analog select upper bits not zero");
    property p_ser_rsv; reg_rd && reg_addr == `PFS_OFS_SERIAL_SEL ##1 1'b1 |-> reg_rdata[15:12] == 4'h0; endproperty
    a_ser_rsv: assert property (p_ser_rsv) else $error("serial select upper bits not zero");
    property p_ana_read; analog_port_read == ($past(analog_pin_in) & analog_port_in_en); endproperty
    a_ana_read: assert property (p_ana_read) else $error("analog port read wrong");
    property p_gen_excl; (gen_pin_oe & gen_pin_pullup) == 4'h0; endproperty
    a_gen_excl: assert property (p_gen_excl) else $error("pull-up on a driven pin");
    property p_tx_own0;
        transmit_enable[0] |=> chan0_transmit_pin_oe && chan0_transmit_pin_out == $past(ser_txd[0]);
    endproperty
    a_tx_own0: assert property (p_tx_own0) else $error("chan0 transmit pin not owned");
    property p_tx_own2;
        transmit_enable[1] |=> chan2_transmit_pin_oe && chan2_transmit_pin_out == $past(ser_txd[1]);
    endproperty
    a_tx_own2: assert property (p_tx_own2) else $error("chan2 transmit pin not owned");
    property p_rx_own0;
        receive_enable[0] |=> !chan0_receive_pin_pullup && ser_rxd[0] == $past(chan0_receive_pin_in);
    endproperty
    a_rx_own0: assert property (p_rx_own0) else $error("chan0 receive pin not owned");
    property p_rx_read2; receive_enable[1] |=> chan2_shared_data_read == $past(chan2_shared_data_bit); endproperty
    a_rx_read2: assert property (p_rx_read2) else $error("chan2 port read not data bit");
endmodule

bind pfs_top pfs_top_chk u_pfs_top_chk (.*);

/* File: testbench/pfs_top_bench.sv */
`timescale 1ns/1ns

`include "pfs_cfg.svh"

`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; $display("FAIL %s exp %h got %h", n, e, g); end end

// ==========================================================================
// Self-checking bench.
module pfs_top_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0, reg_rd = 1'b0, analog_output_enable = 1'b0;
    logic [1:0] transmit_enable = 2'h0, receive_enable = 2'h0, ser_txd = 2'h0, ser_rxd;
    logic [3:0] analog_pin_in = 4'h0, gen_pin_in = 4'h0, gen_periph_out = 4'h0, gen_periph_oe = 4'h0;
    logic [3:0] gen_port_data = 4'h0;
    logic chan0_shared_data_bit = 1'b0, chan0_receive_pin_in = 1'b0;
    logic chan2_shared_data_bit = 1'b0, chan2_receive_pin_in = 1'b0;
    logic [15:0] reg_rdata;
    logic [3:0] analog_port_in_en, analog_port_read, gen_pin_out, gen_pin_oe, gen_pin_pullup, gen_port_read;
    logic chan0_shared_data_read, chan0_transmit_pin_out, chan0_transmit_pin_oe, chan0_receive_pin_pullup;
    logic chan2_shared_data_read, chan2_transmit_pin_out, chan2_transmit_pin_oe, chan2_receive_pin_pullup;
    int n_mismatch = 0;
    int samples_checked = 0;
    int seed = 32'h2AFD;
    logic [15:0] ana, ser;

    pfs_top u_pfs_top (.*);

    always #25 clk = ~clk;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK("reg_rdata", e, reg_rdata)
    endtask

    task automatic chk_chan(input string n, input logic [1:0] f, input logic tx_en, rx_en, txd, db, rp,
                            input logic oe, out, pu, rxd, rdv);
        logic eoe;
        eoe = tx_en | (f == 2'h1);
        `CHK({n, "_oe"}, eoe, oe)
        if (eoe) `CHK({n, "_out"}, (tx_en ? txd : db), out)
        `CHK({n, "_pullup"}, (!rx_en && f == 2'h2), pu)
        `CHK({n, "_rxd"}, ((rx_en || !f[1]) ? rp : 1'b1), rxd)
        `CHK({n, "_read"}, ((!rx_en && f[1]) ? rp : db), rdv)
    endtask

    task automatic check_all();
        logic [1:0] g;
        logic [3:0] eoe, epu, erd, ein;
        logic res;
        chk_chan("ch0", ser[1:0], transmit_enable[0], receive_enable[0], ser_txd[0], chan0_shared_data_bit,
                 chan0_receive_pin_in, chan0_transmit_pin_oe, chan0_transmit_pin_out, chan0_receive_pin_pullup,
                 ser_rxd[0], chan0_shared_data_read);
        chk_chan("ch2", ser[5:4], transmit_enable[1], receive_enable[1], ser_txd[1], chan2_shared_data_bit,
                 chan2_receive_pin_in, chan2_transmit_pin_oe, chan2_transmit_pin_out, chan2_receive_pin_pullup,
                 ser_rxd[1], chan2_shared_data_read);
        res = (ser[11:10] == 2'h1);
        for (int i = 0; i < 4; i++) begin
            g = ser[(i == 0 ? 2 : 4 + 2 * i) +: 2];
            eoe[i] = (g == 2'h0) ? gen_periph_oe[i] : (g == 2'h1 && i != 3);
            epu[i] = (g == 2'h2);
            erd[i] = g[1] ? gen_pin_in[i] : gen_port_data[i];
            ein[i] = ana[2 * i + 1];
            res = res | (ana[2 * i +: 2] == 2'h1);
            if (eoe[i]) `CHK("gen_pin_out", (g[0] ? gen_port_data[i] : gen_periph_out[i]), gen_pin_out[i])
        end
        `CHK("gen_pin_oe", eoe, gen_pin_oe)
        `CHK("gen_pin_pullup", epu, gen_pin_pullup)
        `CHK("gen_port_read", erd, gen_port_read)
        `CHK("analog_port_in_en", ein, analog_port_in_en)
        `CHK("analog_port_read", (ein & analog_pin_in), analog_port_read)
        rd(`PFS_OFS_STATUS, {10'h000, res, analog_output_enable & (|ein), receive_enable[1], transmit_enable[1],
           receive_enable[0], transmit_enable[0]});
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        logic [31:0] r, q;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        ana = 16'h0000;
        ser = 16'h0A88;
        rd(`PFS_OFS_ANALOG_SEL, 16'h0000);
        rd(`PFS_OFS_SERIAL_SEL, 16'h0A88);
        check_all();
        wr(`PFS_OFS_ANALOG_SEL, 16'hFFFF);
        wr(`PFS_OFS_SERIAL_SEL, 16'hFFFF);
        rd(`PFS_OFS_ANALOG_SEL, 16'h00FF);
        rd(`PFS_OFS_SERIAL_SEL, 16'h0FFF);
        rd(4'hE, 16'h0000);
        // The first sixteen passes sweep every field code against every enable pair.
        for (int n = 0; n < 300; n++) begin
            r = $random(seed);
            q = $random(seed);
            if (n < 16) begin
                q[15:0] = {q[15:12], {6{n[1:0]}}};
                r[7:4] = {n[3:2], n[2], n[3]};
            end
            ana = q[31:16] & 16'h00FF;
            ser = q[15:0] & 16'h0FFF;
            @(posedge clk);
            {ser_txd, transmit_enable, receive_enable, chan0_shared_data_bit, chan2_shared_data_bit} <= r[9:2];
            {chan0_receive_pin_in, chan2_receive_pin_in} <= r[11:10];
            {analog_pin_in, gen_pin_in, gen_periph_out, gen_periph_oe, gen_port_data} <= r[31:12];
            analog_output_enable <= r[0] & ~(ana[7] | ana[5] | ana[3] | ana[1]) & ~(|analog_port_in_en);
            wr(`PFS_OFS_ANALOG_SEL, q[31:16]);
            wr(`PFS_OFS_SERIAL_SEL, q[15:0]);
            repeat (2) @(posedge clk);
            #1;
            check_all();
            if (n % 8 == 0) rd(`PFS_OFS_SERIAL_SEL, ser);
        end
        report_and_stop();
    end
endmodule
